/* pkg/sam_pkg.sv */
/*
  Package for the SMBus slave address matcher: register addresses, field
  positions, reset values and the packed carriers shared by the design.
  Assumes an 8-bit special function register bus with byte addresses.
*/
package sam_pkg;

  localparam logic [7:0] SAM_ADDR_SLAVE_CFG = 8'hF4;
  localparam logic [7:0] SAM_ADDR_MASK_CFG  = 8'hF5;

  localparam int SAM_GC_BIT    = 0;
  localparam int SAM_HACK_BIT  = 0;
  localparam int SAM_FIELD_LSB = 1;
  localparam int SAM_FIELD_MSB = 7;

  localparam logic [7:0] SAM_SLAVE_CFG_RST = 8'h00;
  localparam logic [7:0] SAM_MASK_CFG_RST  = 8'hFE;
  localparam logic [6:0] SAM_GC_ADDR       = 7'h00;

  // Special function register access from the CPU.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sam_sfr_req_t;

  // Byte events from the SMBus shifter.
  typedef struct packed {
    logic       byte_done;
    logic       first_byte;
    logic [7:0] rx_byte;
  } sam_rx_evt_t;

endpackage

/* design/sam_matcher.sv */
/*
  SMBus slave address matcher: holds the slave address and mask registers,
  compares the first byte of each frame and drives the hardware acknowledge.
  Assumes the rest of the SMBus unit delivers received bytes with a
  first-byte flag and consumes the acknowledge strobe in the same clock.
*/
// Overview of operation
// - With hardware acknowledge on, matching slave addresses are acknowledged automatically.
// - Hardware acknowledge on answers received data bytes with the software acknowledge value, not automatically.
// - Upper seven bits of address and mask registers decide the acknowledged addresses.
// - Mask bit one requires equal address bit; mask bit zero is don't care.
// - General call address zero is recognised when its enable bit is set, or when it matches the masked own address.
// - Address register: general call enable bit 0, own address bits 7:1, reset zero.
// - With hardware acknowledge off, no byte is acknowledged by the hardware.
`timescale 1ns/10ps
module sam_matcher
(
  // Clock and reset.
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // Register access.
  input  wire sam_pkg::sam_sfr_req_t sfr_req_i,
  output logic [7:0]                 sfr_rdata_o,
  // Received bytes and the software acknowledge value.
  input  wire sam_pkg::sam_rx_evt_t  rx_evt_i,
  input  wire logic                  sw_ack_i,
  // Acknowledge result for the byte just received.
  output logic                       ack_valid_o,
  output logic                       ack_value_o,
  output logic                       addr_match_o,
  output logic                       hw_ack_enable_o
);

  // Width of the address field shared by both registers.
  localparam int FIELD_W = sam_pkg::SAM_FIELD_MSB - sam_pkg::SAM_FIELD_LSB + 1;

  // Register state.
  logic [7:0]         slave_address_config_ff;
  logic [7:0]         address_mask_config_ff;
  logic [7:0]         sfr_rdata_ff;
  // Acknowledge state.
  logic               ack_valid_ff;
  logic               ack_value_ff;
  logic               addr_match_ff;
  logic               hw_ack_enable_ff;
  // Register decode.
  logic               slave_cfg_sel;
  logic               mask_cfg_sel;
  logic               slave_cfg_wr;
  logic               mask_cfg_wr;
  logic [7:0]         nxt_rdata;
  // Address compare.
  logic [FIELD_W-1:0] own_address_field;
  logic [FIELD_W-1:0] address_compare_mask;
  logic [FIELD_W-1:0] rx_address;
  logic [FIELD_W-1:0] addr_diff;
  logic               masked_hit;
  logic               gc_hit;
  logic               general_call_enable;
  logic               hw_ack_enable;
  logic               nxt_match;
  logic               nxt_ack;

  // The compare is built for the general call code width below an eight-bit register.
  if ($bits(sam_pkg::SAM_GC_ADDR) != FIELD_W)
  begin : g_bad_width
    $error("sam_matcher: address field width does not match the general call code");
  end

  if (sam_pkg::SAM_FIELD_MSB >= $bits(slave_address_config_ff))
  begin : g_bad_msb
    $error("sam_matcher: address field does not fit the configuration register");
  end

  // Both enable bits must sit below the address field they share a register with.
  if (sam_pkg::SAM_GC_BIT >= sam_pkg::SAM_FIELD_LSB)
  begin : g_bad_gc
    $error("sam_matcher: general call enable overlaps the address field");
  end

  if (sam_pkg::SAM_HACK_BIT >= sam_pkg::SAM_FIELD_LSB)
  begin : g_bad_hack
    $error("sam_matcher: hardware acknowledge enable overlaps the mask field");
  end

  assign own_address_field    =
    slave_address_config_ff[sam_pkg::SAM_FIELD_MSB:sam_pkg::SAM_FIELD_LSB];
  assign address_compare_mask =
    address_mask_config_ff[sam_pkg::SAM_FIELD_MSB:sam_pkg::SAM_FIELD_LSB];
  assign general_call_enable  = slave_address_config_ff[sam_pkg::SAM_GC_BIT];
  assign hw_ack_enable        = address_mask_config_ff[sam_pkg::SAM_HACK_BIT];
  assign rx_address           =
    rx_evt_i.rx_byte[sam_pkg::SAM_FIELD_MSB:sam_pkg::SAM_FIELD_LSB];

  assign slave_cfg_sel = sfr_req_i.addr == sam_pkg::SAM_ADDR_SLAVE_CFG;
  assign mask_cfg_sel  = sfr_req_i.addr == sam_pkg::SAM_ADDR_MASK_CFG;
  assign slave_cfg_wr  = sfr_req_i.wr && slave_cfg_sel;
  assign mask_cfg_wr   = sfr_req_i.wr && mask_cfg_sel;

  // Address register; every bit is read-write.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      slave_address_config_ff <= sam_pkg::SAM_SLAVE_CFG_RST;
    end
    else if (slave_cfg_wr)
    begin
      slave_address_config_ff <= sfr_req_i.wdata;
    end
  end

  // Mask register; reset leaves hardware acknowledge off.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      address_mask_config_ff <= sam_pkg::SAM_MASK_CFG_RST;
    end
    else if (mask_cfg_wr)
    begin
      address_mask_config_ff <= sfr_req_i.wdata;
    end
  end

  // Unmapped addresses read back as zero.
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (slave_cfg_sel)
    begin
      nxt_rdata = slave_address_config_ff;
    end
    else if (mask_cfg_sel)
    begin
      nxt_rdata = address_mask_config_ff;
    end
  end

  // Read data is captured on the read strobe and holds until the next one.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sfr_rdata_ff <= 8'h00;
    end
    else if (sfr_req_i.rd)
    begin
      sfr_rdata_ff <= nxt_rdata;
    end
  end

  // A zero mask bit makes that address bit a don't care.
  assign addr_diff  = (rx_address ^ own_address_field) & address_compare_mask;
  assign masked_hit = addr_diff == '0;
  assign gc_hit     = general_call_enable && rx_address == sam_pkg::SAM_GC_ADDR;
  assign nxt_match  = masked_hit || gc_hit;

  // With hardware acknowledge on, address bytes answer with the match; otherwise every byte takes the preset software value.
  always_comb
  begin
    nxt_ack = sw_ack_i;
    if (hw_ack_enable)
    begin
      if (rx_evt_i.first_byte)
      begin
        nxt_ack = nxt_match;
      end
      else
      begin
        nxt_ack = sw_ack_i;
      end
    end
  end

  // The acknowledge strobe only fires while hardware acknowledge is on.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_valid_ff <= 1'h0;
    end
    else
    begin
      ack_valid_ff <= rx_evt_i.byte_done && hw_ack_enable;
    end
  end

  // The acknowledge value holds until the next received byte.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_value_ff <= 1'h0;
    end
    else if (rx_evt_i.byte_done)
    begin
      ack_value_ff <= nxt_ack;
    end
  end

  // Only address bytes update the match flag, and one received with acknowledge off clears it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_match_ff <= 1'h0;
    end
    else if (rx_evt_i.byte_done && rx_evt_i.first_byte)
    begin
      addr_match_ff <= nxt_match && hw_ack_enable;
    end
  end

  // Registered copy of the acknowledge enable for the rest of the SMBus unit.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hw_ack_enable_ff <= sam_pkg::SAM_MASK_CFG_RST[sam_pkg::SAM_HACK_BIT];
    end
    else
    begin
      hw_ack_enable_ff <= hw_ack_enable;
    end
  end

  assign sfr_rdata_o     = sfr_rdata_ff;
  assign ack_valid_o     = ack_valid_ff;
  assign ack_value_o     = ack_value_ff;
  assign addr_match_o    = addr_match_ff;
  assign hw_ack_enable_o = hw_ack_enable_ff;

endmodule

/* testbench/sam_master_model.sv */
/* Bus master model: one received byte event per send call; assumes a rising-edge clock. */
`timescale 1ns/10ps
module sam_master_model
(
  // Bus side.
  input  wire logic            clk_i,
  output sam_pkg::sam_rx_evt_t evt_o
);
  initial evt_o = '0;
  task automatic send(input logic f, input logic [7:0] b);
    @(posedge clk_i);
    evt_o <= '{1'b1, f, b};
    @(posedge clk_i);
    evt_o <= '{1'b0, 1'b0, ~b};
  endtask
endmodule

/* testbench/sam_matcher_props.sv */
/* Checker on the sam_matcher ports; assumes it is bound to every instance. */
`timescale 1ns/10ps
module sam_matcher_props
(
  // Clock and reset.
  input wire logic                  sys_clk_i,
  input wire logic                  rst_n_i,
  // Register access.
  input wire sam_pkg::sam_sfr_req_t sfr_req_i,
  input wire logic [7:0]            sfr_rdata_o,
  // Byte events and acknowledge.
  input wire sam_pkg::sam_rx_evt_t  rx_evt_i,
  input wire logic                  sw_ack_i,
  input wire logic                  ack_valid_o,
  input wire logic                  ack_value_o,
  input wire logic                  addr_match_o,
  input wire logic                  hw_ack_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_a; rx_evt_i.byte_done && rx_evt_i.first_byte; endsequence
  sequence s_d; rx_evt_i.byte_done && !rx_evt_i.first_byte; endsequence
  a_ack_gate: assert property (rx_evt_i.byte_done
    |=> ack_valid_o == hw_ack_enable_o) else $error("gate");
  a_ack_cause: assert property (ack_valid_o
    |-> $past(rx_evt_i.byte_done)) else $error("cause");
  a_data_ack: assert property (s_d ##1 hw_ack_enable_o
    |-> ack_value_o == $past(sw_ack_i)) else $error("data");
  a_addr_ack: assert property (s_a ##1 hw_ack_enable_o
    |-> ack_value_o == addr_match_o) else $error("addr");
  a_match_off: assert property (s_a ##1 !hw_ack_enable_o
    |-> !addr_match_o) else $error("off");
  a_value_hold: assert property (!rx_evt_i.byte_done
    |=> $stable(ack_value_o)) else $error("hold");
  a_rdata_hold: assert property (!sfr_req_i.rd
    |=> $stable(sfr_rdata_o)) else $error("rdata");
  a_bad_read: assert property (sfr_req_i.rd && sfr_req_i.addr[7:1] != 7'h7A
    |=> sfr_rdata_o == 8'h00) else $error("unmapped");
endmodule
bind sam_matcher sam_matcher_props u_props (.*);

/* testbench/sam_matcher_tb_top.sv */
/* Bench for sam_matcher; assumes the master model and the bound checker. */
`timescale 1ns/10ps
module sam_matcher_tb_top;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, sw_ack_i = 1'b0;
  logic ack_valid_o, ack_value_o, addr_match_o, hw_ack_enable_o;
  logic [7:0] sfr_rdata_o;
  logic [15:0] cfg [2] = '{16'h69FF, 16'hE0E7};
  logic [6:0] ads [6] = '{7'h00, 7'h34, 7'h35, 7'h74, 7'h78, 7'h71};
  // Bit j is set where ads[j] must be recognised under cfg[i].
  logic [5:0] hit [2] = '{6'h03, 6'h18};
  int fails = 0, checks = 0;
  sam_pkg::sam_sfr_req_t sfr_req_i = '0;
  sam_pkg::sam_rx_evt_t rx_evt_i;
  always #5 sys_clk_i = ~sys_clk_i;
  sam_master_model u_mst (.clk_i(sys_clk_i), .evt_o(rx_evt_i));
  sam_matcher dut (.*);
  task automatic chk(input logic [7:0] g, e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, d);
    @(posedge sys_clk_i);
    sfr_req_i <= '{w, !w, ad, d};
    @(posedge sys_clk_i);
    sfr_req_i <= '0;
    #1;
    if (!w) chk(sfr_rdata_o, d);
  endtask
  task automatic bc(input logic f, input logic [7:0] b, e);
    u_mst.send(f, b);
    #1;
    chk({4'h0, hw_ack_enable_o, ack_valid_o, ack_value_o, addr_match_o}, e);
  endtask
  task automatic test_done;
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    acc(0, 8'hF4, 8'h00);
    acc(0, 8'hF5, 8'hFE);
    bc(1, 8'h68, 8'h00);
    foreach (cfg[i])
    begin
      acc(1, 8'hF4, cfg[i][15:8]);
      acc(1, 8'hF5, cfg[i][7:0]);
      acc(0, 8'hF4, cfg[i][15:8]);
      foreach (ads[j])
      begin
        bc(1, {ads[j], j[0]}, {6'h03, hit[i][j], hit[i][j]});
      end
    end
    @(posedge sys_clk_i);
    sw_ack_i <= 1'b1;
    bc(0, 8'h5A, 8'h0E);
    bc(1, 8'hE2, 8'h0C);
    acc(1, 8'hF5, 8'hFE);
    bc(0, 8'hA5, 8'h02);
    acc(0, 8'h10, 8'h00);
    test_done;
  end
endmodule
